// *** logic/lgcd_defs.vh ***
`ifndef LGCD_DEFS_VH
`define LGCD_DEFS_VH

// ----------------------------------------------------------------------------
// Register indices and bus address width
// ----------------------------------------------------------------------------
`define LGCD_IDX_GATE_LO 12'h0fc
`define LGCD_IDX_GATE_HI 12'h0fd
`define LGCD_IDX_DIV_PERIOD 12'h190
`define LGCD_IDX_DIV_CTRL 12'h191
`define LGCD_IDX_LOCK_CFG 12'h1a0
`define LGCD_IDX_STATUS 12'h1a1
`define LGCD_ADDR_W 12

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define LGCD_PER_LOW_MSB 7
`define LGCD_PER_LOW_LSB 4
`define LGCD_PER_HIGH_MSB 3
`define LGCD_PER_HIGH_LSB 0
`define LGCD_CTL_BYPASS 7
`define LGCD_CTL_NOSYNC 6
`define LGCD_CTL_FORCE 5
`define LGCD_CTL_START 4
`define LGCD_CTL_PHASE_MSB 3
`define LGCD_CTL_PHASE_LSB 0
`define LGCD_CFG_CMP_EN 0
`define LGCD_CFG_CS_MODE 1
`define LGCD_HI_LINES 4

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define LGCD_RST_GATE_LO 8'h00
`define LGCD_RST_GATE_HI 4'h0
`define LGCD_RST_DIV_PERIOD 8'h77
`define LGCD_RST_DIV_CTRL 8'h00
`define LGCD_RST_LOCK_CFG 2'h0

// ----------------------------------------------------------------------------
// Divider states
// ----------------------------------------------------------------------------
`define LGCD_ST_RUN 2'h0
`define LGCD_ST_HOLD 2'h1
`define LGCD_ST_PHASE 2'h2

`endif

// *** logic/lgcd_sync3.v ***
`timescale 1ns/10ps
`default_nettype none

module lgcd_sync3 #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
)
(
    // Clock and reset
    input wire ref_clk,
    input wire nrst,
    // Raw and filtered level
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] level_q
);

    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] stage2_q;
    reg [WIDTH-1:0] stage3_q;
    integer i;

    // --------------------------------------------------------------------
    // Three stages; a change counts only once stages two and three agree.
    // --------------------------------------------------------------------
    always @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            meta_q <= RESET_VAL;
            stage2_q <= RESET_VAL;
            stage3_q <= RESET_VAL;
            level_q <= RESET_VAL;
        end
        else
        begin
            meta_q <= async_in;
            stage2_q <= meta_q;
            stage3_q <= stage2_q;
            for (i = 0; i < WIDTH; i = i + 1)
            begin
                if (stage2_q[i] == stage3_q[i])
                begin
                    level_q[i] <= stage3_q[i];
                end
            end
        end
    end

endmodule // lgcd_sync3

`default_nettype wire

// *** logic/lgcd_divider.v ***
`timescale 1ns/10ps
`default_nettype none
`include "lgcd_defs.vh"

module lgcd_divider #(
    parameter CW = 4
)
(
    // Clock and reset
    input wire ref_clk,
    input wire nrst,
    // One pulse per divider input clock cycle
    input wire chan_tick,
    // Configuration
    input wire [CW-1:0] low_cycles,
    input wire [CW-1:0] high_cycles,
    input wire [CW-1:0] phase_offset,
    input wire bypass,
    input wire ignore_sync,
    input wire force_high,
    input wire start_high,
    // Synchronised chip-level sync, active high
    input wire sync_active,
    // Result
    output reg div_out_q,
    output wire running
);

    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [CW-1:0] cnt_q;
    reg [CW-1:0] cnt_d;
    reg level_q;
    reg level_d;
    reg div_out_d;
    wire sync_hold;

    assign sync_hold = sync_active & ~ignore_sync;
    assign running = (state_q == `LGCD_ST_RUN) & ~bypass;

    // --------------------------------------------------------------------
    // Sequencing
    // --------------------------------------------------------------------
    always @*
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        level_d = level_q;
        if (sync_hold)
        begin
            state_d = `LGCD_ST_HOLD;
            cnt_d = {CW{1'b0}};
            level_d = start_high;
        end
        else
        begin
            case (state_q)
                `LGCD_ST_HOLD:
                begin
                    // Coarse delay counted in input cycles after release.
                    cnt_d = phase_offset;
                    state_d = (phase_offset == {CW{1'b0}}) ? `LGCD_ST_RUN : `LGCD_ST_PHASE;
                    if (phase_offset == {CW{1'b0}})
                    begin
                        cnt_d = {CW{1'b0}};
                    end
                end
                `LGCD_ST_PHASE:
                begin
                    if (chan_tick)
                    begin
                        cnt_d = cnt_q - 1'b1;
                        if (cnt_q == {{(CW-1){1'b0}}, 1'b1})
                        begin
                            state_d = `LGCD_ST_RUN;
                            cnt_d = {CW{1'b0}};
                        end
                    end
                end
                `LGCD_ST_RUN:
                begin
                    // Ratio is (low+1)+(high+1), 2 to 32.
                    if (chan_tick)
                    begin
                        if (level_q && cnt_q == high_cycles)
                        begin
                            level_d = 1'b0;
                            cnt_d = {CW{1'b0}};
                        end
                        else if (!level_q && cnt_q == low_cycles)
                        begin
                            level_d = 1'b1;
                            cnt_d = {CW{1'b0}};
                        end
                        else
                        begin
                            cnt_d = cnt_q + 1'b1;
                        end
                    end
                end
                default:
                begin
                    state_d = `LGCD_ST_RUN;
                    cnt_d = {CW{1'b0}};
                end
            endcase
        end
    end

    // --------------------------------------------------------------------
    // Output selection
    // --------------------------------------------------------------------
    always @*
    begin
        if (force_high)
        begin
            div_out_d = 1'b1;
        end
        else if (bypass)
        begin
            div_out_d = chan_tick;
        end
        else if (state_d == `LGCD_ST_RUN)
        begin
            div_out_d = level_d;
        end
        else
        begin
            div_out_d = 1'b0;
        end
    end

    always @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_q <= `LGCD_ST_RUN;
            cnt_q <= {CW{1'b0}};
            level_q <= 1'b0;
            div_out_q <= 1'b0;
        end
        else
        begin
            // Bypass powers the counter down: it keeps its state frozen.
            if (!bypass)
            begin
                state_q <= state_d;
                cnt_q <= cnt_d;
                level_q <= level_d;
            end
            div_out_q <= div_out_d;
        end
    end

endmodule // lgcd_divider

`default_nettype wire

// *** logic/lgcd_top.v ***
// Functional notes
// - With a line's gating bit set and the lock signal high, the line is enabled unless powered down.
// - With the gating bit clear the lock is ignored; set with lock low, the line is powered down.
// - The first gating register holds lines 0 to 7, line n at bit n, all alike.
// - The second gating register holds lines 8 to 11 in bits 0 to 3.
// - The divider output stays low for the low field plus one input cycles, reset value 7.
// - The divider output stays high for the high field plus one input cycles, reset value 7.
// - Bypass powers the divider down and passes its input straight to the output.
// - With ignore-sync clear the divider obeys chip sync; set, it disregards it.
// - The force bit holds the divider output high when set; when clear the output follows the divider.
// - The start bit chooses whether the divider begins high or low.
// - A four-bit phase offset, reset zero, delays the output by input cycles after sync.
//
// The APB slave port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "lgcd_defs.vh"

module lgcd_top #(
    parameter NLINES = 12,
    parameter CW = 4
)
(
    // Clock and reset
    input wire ref_clk,
    input wire nrst,

    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`LGCD_ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,

    // Lock detect, from the current-source detector, asynchronous
    input wire current_source_lock_signal,

    // Power-down requests from the output driver settings, one per line
    input wire [NLINES-1:0] line_pd,

    // Clock line enables, one per line
    output reg [NLINES-1:0] clock_line_en,

    // Lock detect configuration towards the detector
    output wire lock_detect_pin_cmp_en,
    output wire cs_lock_mode_sel,

    // Channel 0 divider
    input wire chan_tick,
    input wire sync_pin_n,
    output wire div_out,
    output wire div_running
);

    // --------------------------------------------------------------------
    // Address decode
    // --------------------------------------------------------------------
    // Printed offsets are not all word aligned, so each is an index and
    // the byte address is four times that index.
    function hit;
        input [`LGCD_ADDR_W-1:0] addr;
        input [`LGCD_ADDR_W-1:0] idx;
        begin
            hit = (addr == {idx[`LGCD_ADDR_W-3:0], 2'b00});
        end
    endfunction

    wire setup_ph;
    wire access_ph;
    wire wr_en;
    wire rd_en;
    wire hit_gate_lo;
    wire hit_gate_hi;
    wire hit_period;
    wire hit_ctrl;
    wire hit_cfg;
    wire hit_status;
    wire mapped;

    assign setup_ph = psel & ~penable;
    assign access_ph = psel & penable;
    assign hit_gate_lo = hit(paddr, `LGCD_IDX_GATE_LO);
    assign hit_gate_hi = hit(paddr, `LGCD_IDX_GATE_HI);
    assign hit_period = hit(paddr, `LGCD_IDX_DIV_PERIOD);
    assign hit_ctrl = hit(paddr, `LGCD_IDX_DIV_CTRL);
    assign hit_cfg = hit(paddr, `LGCD_IDX_LOCK_CFG);
    assign hit_status = hit(paddr, `LGCD_IDX_STATUS);
    assign mapped = hit_gate_lo | hit_gate_hi | hit_period | hit_ctrl | hit_cfg | hit_status;

    // Zero wait states: every access completes in its first access cycle.
    assign pready = 1'b1;
    // Unmapped addresses, and writes to the read-only status word, fail.
    assign pslverr = access_ph & (~mapped | (pwrite & hit_status));
    assign wr_en = access_ph & pwrite & mapped & ~hit_status;
    assign rd_en = setup_ph & ~pwrite;

    // --------------------------------------------------------------------
    // Configuration registers
    // --------------------------------------------------------------------
    reg [7:0] gate_lo_q;
    reg [`LGCD_HI_LINES-1:0] gate_hi_q;
    reg [7:0] period_q;
    reg [7:0] ctrl_q;
    reg [1:0] cfg_q;

    always @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            gate_lo_q <= `LGCD_RST_GATE_LO;
            gate_hi_q <= `LGCD_RST_GATE_HI;
            period_q <= `LGCD_RST_DIV_PERIOD;
            ctrl_q <= `LGCD_RST_DIV_CTRL;
            cfg_q <= `LGCD_RST_LOCK_CFG;
        end
        else if (wr_en)
        begin
            if (hit_gate_lo)
            begin
                gate_lo_q <= pwdata[7:0];
            end
            if (hit_gate_hi)
            begin
                gate_hi_q <= pwdata[`LGCD_HI_LINES-1:0];
            end
            if (hit_period)
            begin
                period_q <= pwdata[7:0];
            end
            if (hit_ctrl)
            begin
                ctrl_q <= pwdata[7:0];
            end
            if (hit_cfg)
            begin
                cfg_q <= pwdata[1:0];
            end
        end
    end

    // Software must set both of these before relying on lock gating.
    assign lock_detect_pin_cmp_en = cfg_q[`LGCD_CFG_CMP_EN];
    assign cs_lock_mode_sel = cfg_q[`LGCD_CFG_CS_MODE];

    // --------------------------------------------------------------------
    // Input synchronisers
    // --------------------------------------------------------------------
    wire lock_level;
    wire sync_n_level;

    lgcd_sync3 #(
        .WIDTH(1),
        .RESET_VAL(1'b0)
    ) u_lock_sync (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .async_in(current_source_lock_signal),
        .level_q(lock_level)
    );

    // Sync idles high, so its filter resets to the idle level.
    lgcd_sync3 #(
        .WIDTH(1),
        .RESET_VAL(1'b1)
    ) u_syncpin_sync (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .async_in(sync_pin_n),
        .level_q(sync_n_level)
    );

    // --------------------------------------------------------------------
    // Lock-gated line enables
    // --------------------------------------------------------------------
    // The enable follows lock with the filter latency plus one register, four to five clocks,
    // rather than combinationally; this keeps a glitching detector from
    // chopping the output drivers.
    wire [NLINES-1:0] gate_vec;
    wire [NLINES-1:0] line_en_d;

    assign gate_vec = {gate_hi_q, gate_lo_q};
    // A clear bit ignores lock; a set bit needs lock high.
    assign line_en_d = (~gate_vec | {NLINES{lock_level}}) & ~line_pd;

    always @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            clock_line_en <= {NLINES{1'b0}};
        end
        else
        begin
            clock_line_en <= line_en_d;
        end
    end

    // --------------------------------------------------------------------
    // Channel 0 divider
    // --------------------------------------------------------------------
    wire [CW-1:0] low_cycles;
    wire [CW-1:0] high_cycles;
    wire [CW-1:0] phase_offset;

    assign low_cycles = period_q[`LGCD_PER_LOW_MSB:`LGCD_PER_LOW_LSB];
    assign high_cycles = period_q[`LGCD_PER_HIGH_MSB:`LGCD_PER_HIGH_LSB];
    assign phase_offset = ctrl_q[`LGCD_CTL_PHASE_MSB:`LGCD_CTL_PHASE_LSB];

    // Forcing high without ignore-sync is left to software; the output still
    // reads high here, but a sync will restart the counter underneath.
    lgcd_divider #(
        .CW(CW)
    ) u_div0 (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .chan_tick(chan_tick),
        .low_cycles(low_cycles),
        .high_cycles(high_cycles),
        .phase_offset(phase_offset),
        .bypass(ctrl_q[`LGCD_CTL_BYPASS]),
        .ignore_sync(ctrl_q[`LGCD_CTL_NOSYNC]),
        .force_high(ctrl_q[`LGCD_CTL_FORCE]),
        .start_high(ctrl_q[`LGCD_CTL_START]),
        .sync_active(~sync_n_level),
        .div_out_q(div_out),
        .running(div_running)
    );

    // --------------------------------------------------------------------
    // Read path
    // --------------------------------------------------------------------
    // Read data is registered in the setup cycle so that it stands
    // through the access cycle in which the master takes it.
    reg [31:0] rdata_d;

    always @*
    begin
        rdata_d = 32'h0000_0000;
        if (hit_gate_lo)
        begin
            rdata_d[7:0] = gate_lo_q;
        end
        else if (hit_gate_hi)
        begin
            rdata_d[`LGCD_HI_LINES-1:0] = gate_hi_q;
        end
        else if (hit_period)
        begin
            rdata_d[7:0] = period_q;
        end
        else if (hit_ctrl)
        begin
            rdata_d[7:0] = ctrl_q;
        end
        else if (hit_cfg)
        begin
            rdata_d[1:0] = cfg_q;
        end
        else if (hit_status)
        begin
            rdata_d[NLINES-1:0] = clock_line_en;
            rdata_d[16] = lock_level;
            rdata_d[17] = ~sync_n_level;
            rdata_d[18] = div_running;
            rdata_d[19] = div_out;
        end
    end

    always @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            prdata <= 32'h0000_0000;
        end
        else if (rd_en)
        begin
            prdata <= rdata_d;
        end
    end

endmodule // lgcd_top

`default_nettype wire

// *** verification/lgcd_checker.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "lgcd_defs.vh"

module lgcd_checker #(
    parameter NLINES = 12,
    parameter CW = 4
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Register bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`LGCD_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    // Lines and divider
    input wire logic current_source_lock_signal,
    input wire logic [NLINES-1:0] line_pd,
    input wire logic [NLINES-1:0] clock_line_en,
    input wire logic chan_tick,
    input wire logic sync_pin_n,
    input wire logic div_out,
    input wire logic div_running
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    // ------------------------------------------------------------
    // Shadow registers
    // ------------------------------------------------------------
    logic wr;
    logic [NLINES-1:0] gate_q;
    logic [7:0] per_q;
    logic [7:0] ctl_q;
    logic prev_q;
    logic [1:0] clean_q;
    logic [5:0] run_q;

    assign wr = psel && penable && pwrite && pready;

    // A run is judged only from the third toggle after a write, bypass,
    // force or sync, since any of those may cut the run after it short.
    always_ff @(posedge ref_clk or negedge nrst)
        if (!nrst)
        begin
            gate_q <= '0;
            per_q <= 8'h77;
            ctl_q <= 8'h00;
            prev_q <= 1'b0;
            clean_q <= 2'b00;
            run_q <= 6'h00;
        end
        else
        begin
            if (wr && paddr == `LGCD_IDX_GATE_LO * 4)
                gate_q[7:0] <= pwdata[7:0];
            if (wr && paddr == `LGCD_IDX_GATE_HI * 4)
                gate_q[11:8] <= pwdata[3:0];
            if (wr && paddr == `LGCD_IDX_DIV_PERIOD * 4)
                per_q <= pwdata[7:0];
            if (wr && paddr == `LGCD_IDX_DIV_CTRL * 4)
                ctl_q <= pwdata[7:0];
            prev_q <= div_out;
            run_q <= (div_out != prev_q) ? {5'h00, chan_tick} : run_q + {5'h00, chan_tick};
            if (wr || !div_running || ctl_q[7] || ctl_q[5])
                clean_q <= 2'b00;
            else if (div_out != prev_q)
                clean_q <= {clean_q[0], 1'b1};
        end

    property p_pd_off;
        $past(nrst) |-> (clock_line_en & $past(line_pd)) == '0;
    endproperty
    a_pd_off: assert property (p_pd_off)
        else $error("line enabled while powered down");

    property p_ungated_on;
        $past(nrst) |-> (clock_line_en | $past(gate_q) | $past(line_pd)) == '1;
    endproperty
    a_ungated_on: assert property (p_ungated_on)
        else $error("ungated line not enabled");

    property p_gated_off;
        (!current_source_lock_signal) [*8] |-> (clock_line_en & $past(gate_q)) == '0;
    endproperty
    a_gated_off: assert property (p_gated_off)
        else $error("gated line enabled without lock");

    property p_gated_on;
        current_source_lock_signal [*8] |-> clock_line_en == ~$past(line_pd);
    endproperty
    a_gated_on: assert property (p_gated_on)
        else $error("line not enabled with lock");

    property p_run_len;
        (div_out != prev_q) && clean_q[1] && div_running |->
            run_q == (prev_q ? {2'b00, per_q[3:0]} : {2'b00, per_q[7:4]}) + 6'd1;
    endproperty
    a_run_len: assert property (p_run_len)
        else $error("divider run length wrong");

    property p_bypass;
        ctl_q[7] && $past(ctl_q[7]) && !ctl_q[5] |-> div_out == $past(chan_tick);
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("bypass output does not follow input");

    property p_force;
        ctl_q[5] && $past(ctl_q[5]) && !ctl_q[7] |-> div_out;
    endproperty
    a_force: assert property (p_force)
        else $error("forced output not high");

    property p_sync_hold;
        (!sync_pin_n && ctl_q[7:5] == 3'b000) [*8] |-> !div_running && !div_out;
    endproperty
    a_sync_hold: assert property (p_sync_hold)
        else $error("divider not held by sync");

    property p_start;
        $rose(div_running) && ctl_q[7:5] == 3'b000 && !$past(ctl_q[7])
            |-> ##[0:2] div_out == ctl_q[4];
    endproperty
    a_start: assert property (p_start)
        else $error("divider start level wrong");

    c_bypass: cover property (ctl_q[7] && chan_tick);
    c_run: cover property ((div_out != prev_q) && clean_q[1] && div_running);
    c_hold: cover property (!div_running && !sync_pin_n);
endmodule // lgcd_checker

bind lgcd_top lgcd_checker #(.NLINES(NLINES), .CW(CW)) u_lgcd_checker (
    .ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .current_source_lock_signal(current_source_lock_signal), .line_pd(line_pd),
    .clock_line_en(clock_line_en), .chan_tick(chan_tick), .sync_pin_n(sync_pin_n),
    .div_out(div_out), .div_running(div_running)
);
`default_nettype wire

// *** verification/lgcd_clk_sink.sv ***
`timescale 1ns/10ps
`default_nettype none

module lgcd_clk_sink (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Divided clock received
    input wire logic div_out,
    // Length of the last complete low and high runs, in cycles
    output logic [5:0] low_len,
    output logic [5:0] high_len
);
    logic last_q;
    logic [5:0] cnt_q;

    always @(posedge ref_clk or negedge nrst)
        if (!nrst)
        begin
            last_q <= 1'b0;
            cnt_q <= 6'h00;
            low_len <= 6'h00;
            high_len <= 6'h00;
        end
        else if (div_out != last_q)
        begin
            if (last_q)
                high_len <= cnt_q;
            else
                low_len <= cnt_q;
            last_q <= div_out;
            cnt_q <= 6'h01;
        end
        else
            cnt_q <= cnt_q + 6'h01;
endmodule // lgcd_clk_sink
`default_nettype wire

// *** verification/lgcd_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "lgcd_defs.vh"

module lgcd_tb_top;
    localparam logic [11:0] A_GL = `LGCD_IDX_GATE_LO * 4;
    localparam logic [11:0] A_GH = `LGCD_IDX_GATE_HI * 4;
    localparam logic [11:0] A_PER = `LGCD_IDX_DIV_PERIOD * 4;
    localparam logic [11:0] A_CTL = `LGCD_IDX_DIV_CTRL * 4;
    localparam logic [11:0] A_CFG = `LGCD_IDX_LOCK_CFG * 4;
    logic ref_clk, nrst, psel, penable, pwrite, pready, pslverr, lock, chan_tick, sync_pin_n;
    logic div_out, div_running, pin_cmp, cs_mode;
    logic [11:0] paddr, line_pd, line_en;
    logic [31:0] pwdata, prdata;
    logic [5:0] low_len, high_len;
    int mismatches = 0;
    int n_checks = 0;

    lgcd_top u_lgcd_top (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .current_source_lock_signal(lock), .line_pd(line_pd),
        .clock_line_en(line_en), .lock_detect_pin_cmp_en(pin_cmp), .cs_lock_mode_sel(cs_mode),
        .chan_tick(chan_tick), .sync_pin_n(sync_pin_n), .div_out(div_out),
        .div_running(div_running));
    lgcd_clk_sink u_lgcd_clk_sink (.ref_clk(ref_clk), .nrst(nrst), .div_out(div_out),
        .low_len(low_len), .high_len(high_len));

    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    task test_done;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // One transfer; an idle edge always comes before setup.
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
             output logic [31:0] rd, output logic err);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        chk("apb ready", 32'h1, {31'h0, pready});
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wreg(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] x;
        logic e;
        apb(1'b1, a, {24'h0, d}, x, e);
    endtask

    task t_regs;
        logic [31:0] d;
        logic e;
        apb(1'b0, A_GL, 32'h0, d, e);
        chk("gate low reset", 32'h0, d);
        apb(1'b0, A_GH, 32'h0, d, e);
        chk("gate high reset", 32'h0, d);
        apb(1'b0, A_PER, 32'h0, d, e);
        chk("period reset", 32'h77, d);
        apb(1'b0, A_CTL, 32'h0, d, e);
        chk("control reset", 32'h0, d);
        apb(1'b0, 12'h010, 32'h0, d, e);
        chk("unmapped error", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, d);
    endtask

    task t_gating;
        wreg(A_CFG, 8'h03);
        #1 chk("lock config", 32'h3, {30'h0, cs_mode, pin_cmp});
        wreg(A_GL, 8'ha5);
        wreg(A_GH, 8'h06);
        line_pd <= 12'h012;
        cyc(10);
        chk("lines, lock low", 32'h948, {20'h0, line_en});
        lock <= 1'b1;
        cyc(10);
        chk("lines, lock high", 32'hfed, {20'h0, line_en});
        line_pd <= 12'h000;
        lock <= 1'b0;
        wreg(A_GL, 8'h00);
        wreg(A_GH, 8'h00);
        cyc(10);
        chk("lines ungated", 32'hfff, {20'h0, line_en});
    endtask

    task t_period;
        logic [7:0] tbl [4] = '{8'h77, 8'h30, 8'h00, 8'hff};
        for (int i = 0; i < 4; i++)
        begin
            wreg(A_PER, tbl[i]);
            cyc(100);
            chk("low run", {28'h0, tbl[i][7:4]} + 32'h1, {26'h0, low_len});
            chk("high run", {28'h0, tbl[i][3:0]} + 32'h1, {26'h0, high_len});
        end
        wreg(A_PER, 8'h77);
    endtask

    task t_bypass;
        logic p;
        wreg(A_CTL, 8'h80);
        cyc(2);
        for (int i = 0; i < 12; i++)
        begin
            @(posedge ref_clk);
            p = chan_tick;
            chan_tick <= (i % 3) != 0;
            #1 chk("bypass output", {31'h0, p}, {31'h0, div_out});
        end
        @(posedge ref_clk);
        chan_tick <= 1'b1;
    endtask

    task t_force;
        wreg(A_CTL, 8'h60);
        cyc(5);
        chk("forced high", 32'h1, {31'h0, div_out});
        cyc(20);
        chk("forced high later", 32'h1, {31'h0, div_out});
    endtask

    task sync_cycle(input logic [7:0] ctl, output int n);
        wreg(A_CTL, ctl);
        sync_pin_n <= 1'b0;
        cyc(10);
        chk("held by sync", 32'h0, {30'h0, div_running, div_out});
        sync_pin_n <= 1'b1;
        n = 0;
        while (div_running !== 1'b1 && n < 200)
        begin
            @(posedge ref_clk);
            n++;
        end
        cyc(2);
        chk("start level", {31'h0, ctl[4]}, {31'h0, div_out});
    endtask

    task t_sync;
        int n0, n5;
        sync_cycle(8'h10, n0);
        sync_cycle(8'h05, n5);
        chk("phase delay", n0 + 5, n5);
        wreg(A_CTL, 8'h40);
        sync_pin_n <= 1'b0;
        cyc(10);
        chk("sync ignored", 32'h1, {31'h0, div_running});
        sync_pin_n <= 1'b1;
    endtask

    initial
    begin
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        lock = 1'b0;
        line_pd = 12'h000;
        chan_tick = 1'b1;
        sync_pin_n = 1'b1;
        cyc(10);
        nrst <= 1'b1;
        t_regs;
        t_gating;
        t_period;
        t_bypass;
        t_force;
        t_sync;
        cyc(5);
        test_done;
    end

    // About 600 cycles are needed; the limit leaves margin.
    initial
    begin
        #40000;
        mismatches++;
        $display("[FAIL] watchdog expected finish seen timeout");
        test_done;
    end
endmodule // lgcd_tb_top
`default_nettype wire
